// ==== core/pcse_pkg.sv ====
/*
 Package for the pump command sign and enable logic: widths, reset values
 and the carrier structs for control inputs and loop values.
 Assumes a single system clock and synchronous active-low reset.
*/
package pcse_pkg;
	// Width of the signed loop values.
	localparam int PCSE_DATA_W = 16;
	// Depth of the input synchroniser.
	localparam int PCSE_SYNC_STAGES = 2;
	// Reset value of the synchronised control inputs, all off.
	localparam logic [4:0] PCSE_CTRL_RST = 5'h00;
	// Reset value of the fault status output: error shown until known good.
	localparam logic PCSE_FAULT_RST = 1'h0;
	// Reset value of registered data outputs.
	localparam logic [PCSE_DATA_W-1:0] PCSE_DATA_RST = 16'h0000;

	// Raw isolated control inputs, packed in a fixed order.
	typedef struct packed {
		logic drive_enable_input;
		logic feedback_sign_input;
		logic command_sign_input;
		logic aux_sign_input;
		logic ramp_select_input;
	} pcse_ctrl_t;

	// Loop values arriving from the command and feedback path.
	typedef struct packed {
		logic signed [PCSE_DATA_W-1:0] ext_cmd;
		logic [PCSE_DATA_W-1:0] aux_cmd;
		logic signed [PCSE_DATA_W-1:0] feedback;
	} pcse_vals_t;
endpackage : pcse_pkg

// ==== core/pcse_top.sv ====
/*
 Control input and status output logic of a pump displacement controller.
 Isolated inputs gate and sign the command sum, sign the feedback and the
 auxiliary command, and select the ramp. Loop error flags drive the status.
 Assumes control inputs are asynchronous pins and values are on CLK_SYS.
 The loop values and the two loop error flags come from logic on the same
 clock, so they are registered once and reach the outputs one cycle later.
 The control pins pass a two-stage synchroniser first, so their effect on
 the outputs lags the pin change by three clock edges.
 Arithmetic wraps modulo two to the data width; nothing saturates here.
*/
`timescale 1ns/1ps
module pcse_top (
	// Clock and reset.
	input wire logic CLK_SYS,
	input wire logic RESET_N,
	// Isolated control pins.
	input wire pcse_pkg::pcse_ctrl_t CTRL_PINS,
	// Command and feedback values.
	input wire pcse_pkg::pcse_vals_t VALS,
	// Loop error flags.
	input wire logic PUMP_LOOP_ERR,
	input wire logic VALVE_LOOP_ERR,
	// Command sum, feedback and ramp control out.
	output logic signed [pcse_pkg::PCSE_DATA_W-1:0] CMD_SUM,
	output logic signed [pcse_pkg::PCSE_DATA_W-1:0] FEEDBACK_OUT,
	output logic RAMP_ENABLE,
	// Error status: high means no error.
	output logic FAULT_STATUS_OUTPUT
);
	import pcse_pkg::*;

	localparam int W = PCSE_DATA_W;

	// Two's complement negation, used on three paths.
	function automatic logic [W-1:0] neg_if(input logic [W-1:0] v, input logic n);
		neg_if = n ? W'(~v + 1'h1) : v;
	endfunction

	// Synchroniser stages for the five isolated control pins.
	// Only the second stage is decoded, so a metastable first stage never
	// reaches the sign or enable logic.
	logic [4:0] sync1_q;
	logic [4:0] sync2_q;
	pcse_ctrl_t ctrl;
	// Registered outputs; every data output leaves the block from a flip-flop.
	logic signed [W-1:0] cmd_sum_q;
	logic signed [W-1:0] fb_q;
	logic ramp_q;
	logic fault_q;

	// two stage sync
	// The first stage feeds only the second; the pins may change at any time.
	always_ff @(posedge CLK_SYS) begin
		if (!RESET_N) begin
			sync1_q <= PCSE_CTRL_RST;
			sync2_q <= PCSE_CTRL_RST;
		end else begin
			sync1_q <= CTRL_PINS;
			sync2_q <= sync1_q;
		end
	end
	assign ctrl = pcse_ctrl_t'(sync2_q);

	// aux sign first
	// The auxiliary negation is done before summing, so composes on top.
	wire [W-1:0] aux_signed = neg_if(VALS.aux_cmd, ctrl.aux_sign_input);
	wire [W-1:0] raw_sum = W'(VALS.ext_cmd + aux_signed);
	wire [W-1:0] signed_sum = neg_if(raw_sum, ctrl.command_sign_input);
	wire [W-1:0] cmd_sum_d = ctrl.drive_enable_input ? signed_sum : PCSE_DATA_RST;
	wire [W-1:0] fb_d = neg_if(VALS.feedback, ctrl.feedback_sign_input);
	wire fault_d = !(PUMP_LOOP_ERR || VALVE_LOOP_ERR);

	// Output registers. enable only gates the sum; feedback keeps running.
	always_ff @(posedge CLK_SYS) begin
		if (!RESET_N) begin
			cmd_sum_q <= PCSE_DATA_RST;
			fb_q <= PCSE_DATA_RST;
			ramp_q <= 1'h0;
			fault_q <= PCSE_FAULT_RST;
		end else begin
			cmd_sum_q <= cmd_sum_d;
			fb_q <= fb_d;
			ramp_q <= ctrl.ramp_select_input;
			fault_q <= fault_d;
		end
	end

	assign RAMP_ENABLE = ramp_q;
	assign CMD_SUM = cmd_sum_q;
	assign FEEDBACK_OUT = fb_q;
	assign FAULT_STATUS_OUTPUT = fault_q;

	// Checks on the registered outputs and the synchroniser stages. Each output
	// check looks one edge past the decoded control level or the loop error flags,
	// because every output sits behind a flip-flop.
	// Expected values are rebuilt from the raw inputs, not from the wires
	// above, so a slip in the selection logic shows up here.

	// enable gate
	// A low enable must leave a zero sum whatever the commands are.
	a_enable_gates_sum: assert property (
		@(posedge CLK_SYS) disable iff (!RESET_N)
		!ctrl.drive_enable_input |=> CMD_SUM == 0)
		else $error("sum not zero while disabled");

	// loops keep running
	// The feedback path must go on following its input while disabled.
	a_feedback_runs_on: assert property (
		@(posedge CLK_SYS) disable iff (!RESET_N)
		!ctrl.drive_enable_input && !ctrl.feedback_sign_input
		|=> FEEDBACK_OUT == $past(VALS.feedback))
		else $error("feedback stopped while disabled");

	// feedback sign
	// A high feedback sign must give the two's complement of the input.
	a_feedback_sign: assert property (
		@(posedge CLK_SYS) disable iff (!RESET_N)
		ctrl.feedback_sign_input |=> FEEDBACK_OUT == W'(-$past(VALS.feedback)))
		else $error("feedback not negated");

	// feedback passes
	// A low feedback sign must pass the value unchanged, enabled or not.
	a_feedback_passes: assert property (
		@(posedge CLK_SYS) disable iff (!RESET_N)
		!ctrl.feedback_sign_input |=> FEEDBACK_OUT == $past(VALS.feedback))
		else $error("feedback altered without sign");

	// sum sign
	// With only the command sign high the whole sum is negated.
	a_sum_sign: assert property (
		@(posedge CLK_SYS) disable iff (!RESET_N)
		ctrl.drive_enable_input && ctrl.command_sign_input && !ctrl.aux_sign_input
		|=> CMD_SUM == W'(-($past(VALS.ext_cmd) + $past(VALS.aux_cmd))))
		else $error("sum not negated");

	// sum passes
	// With both signs low the sum must pass as the plain addition.
	a_sum_passes: assert property (
		@(posedge CLK_SYS) disable iff (!RESET_N)
		ctrl.drive_enable_input && !ctrl.command_sign_input && !ctrl.aux_sign_input
		|=> CMD_SUM == W'($past(VALS.ext_cmd) + $past(VALS.aux_cmd)))
		else $error("sum altered without sign");

	// aux sign
	// Only the auxiliary term flips, the external command keeps its sign.
	a_aux_sign: assert property (
		@(posedge CLK_SYS) disable iff (!RESET_N)
		ctrl.drive_enable_input && !ctrl.command_sign_input && ctrl.aux_sign_input
		|=> CMD_SUM == W'($past(VALS.ext_cmd) - $past(VALS.aux_cmd)))
		else $error("aux not negated");

	// signs compose
	// Both signs high: the auxiliary term keeps its sign, the external one flips.
	a_signs_compose: assert property (
		@(posedge CLK_SYS) disable iff (!RESET_N)
		ctrl.drive_enable_input && ctrl.command_sign_input && ctrl.aux_sign_input
		|=> CMD_SUM == W'($past(VALS.aux_cmd) - $past(VALS.ext_cmd)))
		else $error("signs do not compose");

	// ramp select
	// The first edge after reset is skipped: the output was reset then,
	// whatever the decoded level was.
	a_ramp_follows: assert property (
		@(posedge CLK_SYS) disable iff (!RESET_N)
		$past(RESET_N) |-> RAMP_ENABLE == $past(ctrl.ramp_select_input))
		else $error("ramp select not followed");

	// ramp bypass
	// A low select must leave the ramp bypassed on the next edge.
	a_ramp_bypassed: assert property (
		@(posedge CLK_SYS) disable iff (!RESET_N)
		!ctrl.ramp_select_input |=> !RAMP_ENABLE)
		else $error("ramp on without select");

	// status good
	// No error on either loop must show a high status.
	a_status_good: assert property (
		@(posedge CLK_SYS) disable iff (!RESET_N)
		!PUMP_LOOP_ERR && !VALVE_LOOP_ERR |=> FAULT_STATUS_OUTPUT)
		else $error("status low without error");

	// status error
	// Either loop in error must pull the status low for the interlock.
	a_status_error: assert property (
		@(posedge CLK_SYS) disable iff (!RESET_N)
		PUMP_LOOP_ERR || VALVE_LOOP_ERR |=> !FAULT_STATUS_OUTPUT)
		else $error("status high with error");

	// first stage
	// The first stage must hold what the pins showed one edge earlier.
	a_sync_first: assert property (
		@(posedge CLK_SYS) disable iff (!RESET_N)
		$past(RESET_N) |-> sync1_q == $past(CTRL_PINS))
		else $error("first stage not loaded");

	// two stage sync
	// Both earlier edges must be out of reset, or a stage held its reset value.
	a_sync_delay: assert property (
		@(posedge CLK_SYS) disable iff (!RESET_N)
		$past(RESET_N, 2) && $past(RESET_N) |-> sync2_q == $past(CTRL_PINS, 2))
		else $error("sync not two stages");

	// enable from second stage
	// The gate must act on the synchronised level, never on the raw pin.
	a_gate_uses_sync: assert property (
		@(posedge CLK_SYS) disable iff (!RESET_N)
		!sync2_q[4] |=> CMD_SUM == 0)
		else $error("gate not on synchronised enable");
endmodule // pcse_top

// ==== tb/pcse_plc.sv ====
/* Far-side controller model: drives the isolated pins, loop values and
 loop error flags. Seeds its own generator on its first edge; assumes the bench sets the mode. */
`timescale 1ns/1ps
module pcse_plc import pcse_pkg::*; (
	// Clock and mode.
	input wire logic clk,
	input wire logic rnd,
	input wire logic [4:0] fix,
	// Levels towards the block.
	output pcse_ctrl_t pins = '0,
	output pcse_vals_t vals = '0,
	output logic [1:0] errs = '0
);
	// The generator of this process is seeded once, on its first edge.
	bit seeded = 1'h0;
	// Pins are free-running levels, so any change in any cycle is legal.
	always @(posedge clk) begin
		if (!seeded) begin
			seeded = 1'h1;
			void'($urandom(32'h73d32e1b));
		end
		pins <= rnd ? 5'($urandom) : fix;
		vals <= 48'({$urandom, $urandom});
		errs <= 2'($urandom);
	end
endmodule // pcse_plc

// ==== tb/test_pcse_top.sv ====
/* Self-checking bench for the pump command sign and enable logic.
 Assumes the far-side model above and the registered outputs of the block. */
`timescale 1ns/1ps
module test_pcse_top;
	import pcse_pkg::*;
	logic clk = 0;
	logic rst_n = 0;
	logic rnd = 1;
	logic [4:0] fix = 0;
	pcse_ctrl_t pins;
	pcse_vals_t vals;
	logic [1:0] errs;
	logic signed [15:0] sum, fb;
	logic ramp, st;
	logic e_ramp, e_st;
	logic [4:0] s1, s2;
	logic [15:0] a, e_sum, e_fb;
	int miscompares = 0;
	int n_tests = 0;
	int live = 0;
	// Clock, 4 ns period.
	always #2 clk = ~clk;
	pcse_plc pcse_plc_inst(.clk(clk), .rnd(rnd), .fix(fix), .pins(pins), .vals(vals),
		.errs(errs));
	pcse_top pcse_top_inst(.CLK_SYS(clk), .RESET_N(rst_n), .CTRL_PINS(pins), .VALS(vals),
		.PUMP_LOOP_ERR(errs[1]), .VALVE_LOOP_ERR(errs[0]), .CMD_SUM(sum),
		.FEEDBACK_OUT(fb), .RAMP_ENABLE(ramp), .FAULT_STATUS_OUTPUT(st));
	task automatic chk(input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %0t exp %h got %h", $time, e, g);
		end
	endtask
	task test_done;
		$display("comparisons %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Reference model; pins take two stages, so effects lag by three edges.
	always @(posedge clk) begin
		a = s2[1] ? -vals.aux_cmd : vals.aux_cmd;
		e_sum = s2[4] ? (s2[2] ? -(vals.ext_cmd + a) : vals.ext_cmd + a) : 16'h0000;
		e_fb = s2[3] ? -vals.feedback : vals.feedback;
		e_ramp = s2[0];
		e_st = ~|errs;
		s2 = rst_n ? s1 : 5'h00;
		s1 = rst_n ? pins : 5'h00;
		live = rst_n ? live + 1 : 0;
	end
	// Outputs are compared mid-cycle, once the reset pipeline has drained.
	always @(negedge clk) begin
		if (live > 3) begin
			chk(e_sum, sum);
			chk(e_fb, fb);
			chk({15'h0, e_ramp}, {15'h0, ramp});
			chk({15'h0, e_st}, {15'h0, st});
		end
	end
	// Random levels, then every pin code held steady, then a mid-run reset.
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1;
		repeat (500) @(posedge clk);
		$display("random test done");
		rnd <= 0;
		for (int i = 0; i < 32; i++) begin
			fix <= 5'(i);
			repeat (6) @(posedge clk);
		end
		$display("code table test done");
		rst_n <= 0;
		repeat (4) @(posedge clk);
		rst_n <= 1;
		repeat (50) @(posedge clk);
		$display("reset test done");
		test_done();
	end
	// Watchdog, well beyond the roughly 800 cycles the tests need.
	initial begin
		#8000;
		miscompares++;
		test_done();
	end
endmodule // test_pcse_top
